// ---- rtl/eeiu_top.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// [RL1] Falling interrupt enable bits 15..0, one per line, gate falling requests.
// [RL2] Rising interrupt enable bits 15..0, one per line, gate rising requests.
// [RL3] Lines 0..7 take 4-bit port selects: 0 port A, 1 B, 2 C.
// [RL4] Lines 8..15 take a second select register, same code, same pin number.
// [RL5] Falling transitions are detected only while the line's detect bit is set.
// [RL6] Rising transitions are detected only while the line's detect bit is set.
// [RL7] Reset clears all enables and selects: port A, nothing detected or requested.
// [RL8] Number n vectors at 0x40 plus 4n; lines group onto numbers 0..3.
// [RL9] Only exceptions, lines, clock fail, base timer, comparator, touch wake STOP.
// [RL10] A vector reaches the core only with core enable and module mask set.
// [RL11] Several gated flags sharing one vector are ORed onto it.
// [RL12] Clock failure uses number 4, gated by the clock unit enable, wakes STOP.
// [RL13] A detected falling edge sets the line's falling flag until software clears.
// [RL14] A detected rising edge sets the line's rising flag until software clears.
// [RL15] Software writing one to an edge flag sets it like a real edge.
// [RL16] Line requests when an enabled flag is set; shared-vector lines are ORed.
// [RL17] The selected pin is synchronised, then compared with its previous sample.
module eeiu_top (
    input  wire logic                   clk,             // System clock.
    input  wire logic                   srst,            // Sync reset, high.
    input  wire eeiu_pkg::eeiu_avs_req_s avs,            // Avalon request.
    output logic [31:0]                 avs_readdata,    // Avalon read data.
    output logic                        avs_waitrequest, // Avalon stall.
    input  wire eeiu_pkg::eeiu_pins_s   pins,            // Raw port pins.
    input  wire eeiu_pkg::eeiu_wake_src_s wake_src,      // Other wake sources.
    output logic [4:0]                  core_irq,        // Vector requests.
    output logic [31:0]                 pend_vec_addr,   // Lowest pending vec.
    output logic                        stop_wake,       // STOP wake request.
    output logic                        irq              // Event interrupt.
);

    logic [15:0] fall_irq_en;
    logic [15:0] rise_irq_en;
    logic [31:0] line_source_select_low;
    logic [31:0] line_source_select_high;
    logic [15:0] fall_detect_en;
    logic [15:0] rise_detect_en;
    logic [15:0] fall_edge_flag;
    logic [15:0] rise_edge_flag;
    logic [15:0] evt_status;
    logic [15:0] evt_mask;
    logic [4:0]  core_en;

    eeiu_pkg::eeiu_pins_s    pins_s1;
    eeiu_pkg::eeiu_pins_s    pins_s2;
    logic [15:0]             line_now;
    logic [15:0]             line_prev;
    logic [15:0]             fall_hit;
    logic [15:0]             rise_hit;
    logic [15:0]             line_req;
    logic [4:0]              vec_req;
    logic [4:0]              next_core_irq;
    logic [31:0]             next_pend_vec_addr;
    logic                    next_stop_wake;

    eeiu_pkg::eeiu_bus_state_e bus_state;
    logic                    access;
    logic                    wr_fire;
    logic                    rd_take;

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic pick_pin(input logic [3:0] code,
                                      input logic       a,
                                      input logic       b,
                                      input logic       c);
        logic r;
        case (code)
            eeiu_pkg::SEL_PORT_A: r = a;
            eeiu_pkg::SEL_PORT_B: r = b;
            eeiu_pkg::SEL_PORT_C: r = c;
            default:              r = eeiu_pkg::RSVD_SEL_LEVEL;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] vector_address(input logic [4:0] n);
        return eeiu_pkg::VEC_BASE + {25'h0, n, 2'b00};
    endfunction

    function automatic logic [31:0] read_mux(input logic [8:0] addr);
        logic [31:0] r;
        r = eeiu_pkg::RST_WORD;
        case (addr)
            eeiu_pkg::OFS_FALL_IRQ_EN: r = {16'h0, fall_irq_en};
            eeiu_pkg::OFS_RISE_IRQ_EN: r = {16'h0, rise_irq_en};
            eeiu_pkg::OFS_SEL_LOW:     r = line_source_select_low;
            eeiu_pkg::OFS_SEL_HIGH:    r = line_source_select_high;
            eeiu_pkg::OFS_FALL_DET_EN: r = {16'h0, fall_detect_en};
            eeiu_pkg::OFS_RISE_DET_EN: r = {16'h0, rise_detect_en};
            eeiu_pkg::OFS_FALL_FLAG:   r = {16'h0, fall_edge_flag};
            eeiu_pkg::OFS_RISE_FLAG:   r = {16'h0, rise_edge_flag};
            eeiu_pkg::OFS_EVT_STATUS:  r = {16'h0, evt_status};
            eeiu_pkg::OFS_EVT_MASK:    r = {16'h0, evt_mask};
            eeiu_pkg::OFS_CORE_EN:     r = {27'h0, core_en};
            default:                   r = eeiu_pkg::RST_WORD;
        endcase
        return r;
    endfunction

    // Every access stalls exactly one cycle so read data can be registered.
    assign access          = avs.read | avs.write;
    assign avs_waitrequest = access & (bus_state == eeiu_pkg::EEIU_BUS_IDLE);
    assign wr_fire = avs.write & (bus_state == eeiu_pkg::EEIU_BUS_DONE);
    assign rd_take = avs.read & (bus_state == eeiu_pkg::EEIU_BUS_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_state <= eeiu_pkg::EEIU_BUS_IDLE;
        end else begin
            case (bus_state)
                eeiu_pkg::EEIU_BUS_IDLE: begin
                    if (access) begin
                        bus_state <= eeiu_pkg::EEIU_BUS_DONE;
                    end
                end
                eeiu_pkg::EEIU_BUS_DONE: bus_state <= eeiu_pkg::EEIU_BUS_IDLE;
                default:                 bus_state <= eeiu_pkg::EEIU_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= eeiu_pkg::RST_WORD;
        end else if (rd_take) begin
            avs_readdata <= read_mux(avs.address);
        end
    end

    // Configuration registers; all clear to zero so every line picks port A.
    always_ff @(posedge clk) begin
        if (srst) begin
            fall_irq_en             <= eeiu_pkg::RST_HALF; // RL7
            rise_irq_en             <= eeiu_pkg::RST_HALF;
            line_source_select_low  <= eeiu_pkg::RST_WORD;
            line_source_select_high <= eeiu_pkg::RST_WORD;
            fall_detect_en          <= eeiu_pkg::RST_HALF;
            rise_detect_en          <= eeiu_pkg::RST_HALF;
            evt_mask                <= eeiu_pkg::RST_HALF;
            core_en                 <= eeiu_pkg::RST_CORE_EN;
        end else if (wr_fire) begin
            case (avs.address)
                eeiu_pkg::OFS_FALL_IRQ_EN: fall_irq_en <= 16'(merge_be( // RL1
                    {16'h0, fall_irq_en}, avs.writedata, avs.byteenable));
                eeiu_pkg::OFS_RISE_IRQ_EN: rise_irq_en <= 16'(merge_be( // RL2
                    {16'h0, rise_irq_en}, avs.writedata, avs.byteenable));
                eeiu_pkg::OFS_SEL_LOW: line_source_select_low <= merge_be(
                    line_source_select_low, avs.writedata,
                    avs.byteenable); // RL3
                eeiu_pkg::OFS_SEL_HIGH: line_source_select_high <= merge_be(
                    line_source_select_high, avs.writedata,
                    avs.byteenable); // RL4
                eeiu_pkg::OFS_FALL_DET_EN: fall_detect_en <= 16'(merge_be(
                    {16'h0, fall_detect_en}, avs.writedata, avs.byteenable));
                eeiu_pkg::OFS_RISE_DET_EN: rise_detect_en <= 16'(merge_be(
                    {16'h0, rise_detect_en}, avs.writedata, avs.byteenable));
                eeiu_pkg::OFS_EVT_MASK: evt_mask <= 16'(merge_be(
                    {16'h0, evt_mask}, avs.writedata, avs.byteenable));
                eeiu_pkg::OFS_CORE_EN: core_en <= 5'(merge_be(
                    {27'h0, core_en}, avs.writedata, avs.byteenable));
                default: ;
            endcase
        end
    end

    // Two-stage synchroniser on every pin; only stage two is ever decoded.
    // Reset to the pulled-up idle level, so no false edge follows reset.
    always_ff @(posedge clk) begin
        if (srst) begin
            pins_s1 <= '1;
            pins_s2 <= '1;
        end else begin
            pins_s1 <= pins; // RL17
            pins_s2 <= pins_s1;
        end
    end

    always_comb begin
        logic [63:0] sel_all;
        sel_all = {line_source_select_high, line_source_select_low};
        for (int i = 0; i < eeiu_pkg::NUM_LINES; i++) begin
            line_now[i] = pick_pin(sel_all[4*i +: 4], // RL3 RL4
                                   pins_s2.port_a[i],
                                   pins_s2.port_b[i],
                                   pins_s2.port_c[i]);
        end
    end

    // Changing a line's select can itself look like an edge on that line.
    always_ff @(posedge clk) begin
        if (srst) begin
            line_prev <= ~eeiu_pkg::RST_HALF;
        end else begin
            line_prev <= line_now; // RL17
        end
    end

    assign fall_hit = ~line_now & line_prev & fall_detect_en; // RL5
    assign rise_hit = line_now & ~line_prev & rise_detect_en; // RL6

    // Writing the flag register stores the written bits, so a one sets and a
    // zero clears; a hardware edge in the same cycle still wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            fall_edge_flag <= eeiu_pkg::RST_HALF;
            rise_edge_flag <= eeiu_pkg::RST_HALF;
        end else begin
            if (wr_fire && avs.address == eeiu_pkg::OFS_FALL_FLAG) begin
                fall_edge_flag <= 16'(merge_be({16'h0, fall_edge_flag},
                    avs.writedata, avs.byteenable)) | fall_hit; // RL15
            end else begin
                fall_edge_flag <= fall_edge_flag | fall_hit; // RL13
            end
            if (wr_fire && avs.address == eeiu_pkg::OFS_RISE_FLAG) begin
                rise_edge_flag <= 16'(merge_be({16'h0, rise_edge_flag},
                    avs.writedata, avs.byteenable)) | rise_hit; // RL15
            end else begin
                rise_edge_flag <= rise_edge_flag | rise_hit; // RL14
            end
        end
    end

    // Sticky per-line edge events, write one to clear, set wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            evt_status <= eeiu_pkg::RST_HALF;
        end else if (wr_fire && avs.address == eeiu_pkg::OFS_EVT_STATUS) begin
            evt_status <= (evt_status & ~16'(merge_be(32'h0, avs.writedata,
                avs.byteenable))) | fall_hit | rise_hit;
        end else begin
            evt_status <= evt_status | fall_hit | rise_hit;
        end
    end

    assign line_req = (fall_edge_flag & fall_irq_en)  // RL1 RL16
                    | (rise_edge_flag & rise_irq_en); // RL2

    assign vec_req[0] = |(line_req & eeiu_pkg::LINES_VEC0); // RL8
    assign vec_req[1] = |(line_req & eeiu_pkg::LINES_VEC1); // RL11 RL16
    assign vec_req[2] = |(line_req & eeiu_pkg::LINES_VEC2); // RL11
    assign vec_req[3] = |(line_req & eeiu_pkg::LINES_VEC3); // RL11
    assign vec_req[eeiu_pkg::VEC_CLK_FAIL] = wake_src.clock_fail_flag
                                           & wake_src.clock_unit_irq_en; // RL12

    assign next_core_irq = vec_req & core_en; // RL10

    always_comb begin
        next_pend_vec_addr = eeiu_pkg::RST_WORD;
        for (int k = eeiu_pkg::NUM_VEC - 1; k >= 0; k--) begin
            if (next_core_irq[k]) begin
                next_pend_vec_addr = vector_address(5'(k)); // RL8
            end
        end
    end

    assign next_stop_wake = (|line_req) | vec_req[eeiu_pkg::VEC_CLK_FAIL]
                          | wake_src.base_timer_req | wake_src.comparator_req
                          | wake_src.touch_unit_req
                          | wake_src.core_exc_req; // RL9 RL12

    always_ff @(posedge clk) begin
        if (srst) begin
            core_irq      <= eeiu_pkg::RST_CORE_EN;
            pend_vec_addr <= eeiu_pkg::RST_WORD;
            stop_wake     <= 1'b0;
            irq           <= 1'b0;
        end else begin
            core_irq      <= next_core_irq; // RL10
            pend_vec_addr <= next_pend_vec_addr;
            stop_wake     <= next_stop_wake; // RL9
            irq           <= |(evt_status & evt_mask);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_stall_first;
        access && bus_state == eeiu_pkg::EEIU_BUS_IDLE && avs_waitrequest;
    endsequence

    sequence s_answer_next;
        !avs_waitrequest;
    endsequence

    chk_bus_one_wait: assert property (
        s_stall_first ##1 access |-> s_answer_next)
        else $error("access not answered one cycle after the stall");

    chk_fall_flag_set: assert property ( // RL13
        |fall_hit |=> ((fall_edge_flag & $past(fall_hit)) == $past(fall_hit)))
        else $error("falling edge did not set its flag");

    chk_rise_flag_set: assert property ( // RL14
        |rise_hit |=> ((rise_edge_flag & $past(rise_hit)) == $past(rise_hit)))
        else $error("rising edge did not set its flag");

    chk_fall_detect_off: assert property ( // RL5
        (fall_detect_en == 16'h0000 && !wr_fire)
        |=> fall_edge_flag == $past(fall_edge_flag))
        else $error("falling flag changed with detection disabled");

    chk_rise_detect_off: assert property ( // RL6
        (rise_detect_en == 16'h0000 && !wr_fire)
        |=> rise_edge_flag == $past(rise_edge_flag))
        else $error("rising flag changed with detection disabled");

    chk_flag_sw_set: assert property ( // RL15
        (wr_fire && avs.address == eeiu_pkg::OFS_FALL_FLAG
         && avs.byteenable[0] && avs.writedata[0]) |=> fall_edge_flag[0])
        else $error("software write of one did not set the flag");

    chk_vec_group_or: assert property ( // RL16
        (|(line_req & eeiu_pkg::LINES_VEC1) && core_en[1]) |=> core_irq[1])
        else $error("grouped line request missing on its vector");

    chk_core_gate: assert property ( // RL10
        (!core_en[2] || !(|(line_req & eeiu_pkg::LINES_VEC2)))
        |=> !core_irq[2])
        else $error("vector raised without core enable or line request");

    chk_clk_fail_gate: assert property ( // RL12
        (wake_src.clock_fail_flag && wake_src.clock_unit_irq_en
         && core_en[4]) |=> core_irq[4] && stop_wake)
        else $error("clock failure request not raised on number four");

    chk_vec_address: assert property ( // RL8
        core_irq[0] |-> pend_vec_addr == eeiu_pkg::VEC_BASE)
        else $error("line zero vector address wrong");

    chk_wake_only: assert property ( // RL9
        (line_req == 16'h0000 && wake_src == '0) |=> !stop_wake)
        else $error("STOP wake raised with no wake source");

    chk_reset_clear: assert property ( // RL7
        $past(srst) |-> (fall_irq_en == 16'h0000 && rise_irq_en == 16'h0000
        && line_source_select_low == 32'h0 && fall_detect_en == 16'h0000))
        else $error("configuration not cleared by reset");

    chk_fall_flag_hold: assert property ( // RL13
        !(wr_fire && avs.address == eeiu_pkg::OFS_FALL_FLAG)
        |=> (fall_edge_flag & $past(fall_edge_flag)) == $past(fall_edge_flag))
        else $error("falling flag dropped without a software write");

    chk_rise_flag_hold: assert property ( // RL14
        !(wr_fire && avs.address == eeiu_pkg::OFS_RISE_FLAG)
        |=> (rise_edge_flag & $past(rise_edge_flag)) == $past(rise_edge_flag))
        else $error("rising flag dropped without a software write");

    chk_event_irq: assert property (
        |(evt_status & evt_mask) |=> irq)
        else $error("unmasked event did not raise the interrupt");

    chk_core_en_write: assert property ( // RL10
        (wr_fire && avs.byteenable[0]
         && avs.address == eeiu_pkg::OFS_CORE_EN)
        |=> core_en == $past(avs.writedata[4:0]))
        else $error("core enable write did not land");

    chk_route_low_b: assert property ( // RL3
        line_source_select_low[23:20] == eeiu_pkg::SEL_PORT_B
        |-> line_now[5] == pins_s2.port_b[5])
        else $error("line five not routed from port B");

    chk_route_high_c: assert property ( // RL4
        line_source_select_high[15:12] == eeiu_pkg::SEL_PORT_C
        |-> line_now[11] == pins_s2.port_c[11])
        else $error("line eleven not routed from port C");

endmodule // eeiu_top

// ---- rtl/eeiu_pkg.sv ----
package eeiu_pkg;

    localparam int NUM_LINES = 16;
    localparam int NUM_VEC   = 5;
    localparam int ADDR_W    = 9;

    localparam logic [8:0] OFS_FALL_IRQ_EN  = 9'h000;
    localparam logic [8:0] OFS_RISE_IRQ_EN  = 9'h020;
    localparam logic [8:0] OFS_SEL_LOW      = 9'h040;
    localparam logic [8:0] OFS_SEL_HIGH     = 9'h060;
    localparam logic [8:0] OFS_FALL_DET_EN  = 9'h080;
    localparam logic [8:0] OFS_RISE_DET_EN  = 9'h0a0;
    localparam logic [8:0] OFS_FALL_FLAG    = 9'h0c0;
    localparam logic [8:0] OFS_RISE_FLAG    = 9'h0e0;
    localparam logic [8:0] OFS_EVT_STATUS   = 9'h100;
    localparam logic [8:0] OFS_EVT_MASK     = 9'h104;
    localparam logic [8:0] OFS_CORE_EN      = 9'h108;

    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [15:0] RST_HALF        = 16'h0000;
    localparam logic [4:0]  RST_CORE_EN     = 5'h00;

    localparam logic [3:0]  SEL_PORT_A      = 4'h0;
    localparam logic [3:0]  SEL_PORT_B      = 4'h1;
    localparam logic [3:0]  SEL_PORT_C      = 4'h2;
    localparam logic        RSVD_SEL_LEVEL  = 1'b1;

    localparam logic [31:0] VEC_BASE        = 32'h0000_0040;
    localparam logic [15:0] LINES_VEC0      = 16'h0001;
    localparam logic [15:0] LINES_VEC1      = 16'h00fe;
    localparam logic [15:0] LINES_VEC2      = 16'h0f00;
    localparam logic [15:0] LINES_VEC3      = 16'hf000;
    localparam int          VEC_CLK_FAIL    = 4;

    typedef enum logic [1:0] {
        EEIU_BUS_IDLE = 2'b01,
        EEIU_BUS_DONE = 2'b10
    } eeiu_bus_state_e;

    typedef struct packed {
        logic [8:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } eeiu_avs_req_s;

    typedef struct packed {
        logic [15:0] port_a;
        logic [15:0] port_b;
        logic [15:0] port_c;
    } eeiu_pins_s;

    typedef struct packed {
        logic clock_fail_flag;
        logic clock_unit_irq_en;
        logic base_timer_req;
        logic comparator_req;
        logic touch_unit_req;
        logic core_exc_req;
    } eeiu_wake_src_s;

endpackage

// ---- tb/eeiu_far_model.sv ----
`timescale 1ns/10ps
module eeiu_far_model (
    input  wire logic                     clk,           // System clock.
    input  wire logic                     srst,          // Sync reset, high.
    input  wire logic [4:0]               core_irq,      // Vector requests.
    input  wire logic [31:0]              pend_vec_addr, // Pending vector.
    output eeiu_pkg::eeiu_pins_s          pins,          // Pin levels.
    output eeiu_pkg::eeiu_wake_src_s      wake_src,      // Wake sources.
    output logic [31:0]                   taken_vec      // Last vector taken.
);
    // Pins are pulled up, so an idle line sits high.
    initial begin
        pins = '1;
        wake_src = '0;
    end

    // The core latches the vector it would fetch while a request stands.
    always_ff @(posedge clk) begin
        if (srst) begin
            taken_vec <= 32'h0000_0000;
        end else if (|core_irq) begin
            taken_vec <= pend_vec_addr;
        end
    end

    task automatic set_pin(input int port, input int line, input logic lvl);
        @(posedge clk);
        case (port)
            0: pins.port_a[line] <= lvl;
            1: pins.port_b[line] <= lvl;
            default: pins.port_c[line] <= lvl;
        endcase
    endtask

    task automatic set_wake(input logic [5:0] w);
        @(posedge clk);
        wake_src <= w;
    endtask
endmodule // eeiu_far_model

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic                     clk;
    logic                     srst;
    eeiu_pkg::eeiu_avs_req_s  avs;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    eeiu_pkg::eeiu_pins_s     pins;
    eeiu_pkg::eeiu_wake_src_s wake_src;
    logic [4:0]               core_irq;
    logic [31:0]              pend_vec_addr;
    logic                     stop_wake;
    logic                     irq;
    logic [31:0]              taken_vec;
    int                       mismatches;
    int                       samples_checked;

    eeiu_top i_eeiu_top (.clk(clk), .srst(srst), .avs(avs),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pins(pins), .wake_src(wake_src), .core_irq(core_irq),
        .pend_vec_addr(pend_vec_addr), .stop_wake(stop_wake), .irq(irq));

    eeiu_far_model i_eeiu_far_model (.clk(clk), .srst(srst),
        .core_irq(core_irq), .pend_vec_addr(pend_vec_addr), .pins(pins),
        .wake_src(wake_src), .taken_vec(taken_vec));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One Avalon access; the request stands until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [8:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs <= '{address: a, read: !wr, write: wr, writedata: d,
                 byteenable: 4'hf};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs.read <= 1'b0;
        avs.write <= 1'b0;
        if (n == 20) begin
            mismatches++;
            $display("unexpected at %0t: bus stalled", $time);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic cr(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        ck(q, exp);
    endtask

    task automatic pin(input int p, input int l, input logic v);
        i_eeiu_far_model.set_pin(p, l, v);
        repeat (6) @(posedge clk);
    endtask

    task automatic s_reset();
        for (int i = 0; i < 8; i++) begin
            cr(9'(i * 32), 32'h0000_0000);
        end
        cr(9'h1fc, 32'h0000_0000);
        ck({27'h0, core_irq}, 32'h0000_0000);
        ck({30'h0, irq, stop_wake}, 32'h0000_0000);
    endtask

    task automatic s_rw();
        for (int i = 0; i < 6; i++) begin
            wr(9'(i * 32), 32'hffff_ffff);
            cr(9'(i * 32), (i == 2 || i == 3) ? '1 : 32'h0000_ffff);
            wr(9'(i * 32), 32'h0000_0000);
        end
    endtask

    // Line 5 on port B, line 11 on port C; others stay on port A.
    task automatic s_route();
        wr(eeiu_pkg::OFS_SEL_LOW, 32'h0010_0000);
        wr(eeiu_pkg::OFS_SEL_HIGH, 32'h0000_2000);
        wr(eeiu_pkg::OFS_RISE_DET_EN, 32'h0000_ffff);
        pin(0, 5, 1'b0);
        pin(0, 5, 1'b1);
        cr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0000);
        pin(1, 5, 1'b0);
        cr(eeiu_pkg::OFS_FALL_FLAG, 32'h0000_0000);
        pin(1, 5, 1'b1);
        cr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0020);
        pin(2, 11, 1'b0);
        pin(2, 11, 1'b1);
        cr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0820);
        wr(eeiu_pkg::OFS_FALL_DET_EN, 32'h0000_ffff);
        pin(1, 5, 1'b0);
        pin(1, 5, 1'b1);
        cr(eeiu_pkg::OFS_FALL_FLAG, 32'h0000_0020);
        wr(eeiu_pkg::OFS_CORE_EN, 32'h0000_001f);
        repeat (3) @(posedge clk);
        ck({27'h0, core_irq}, 32'h0000_0000);
        wr(eeiu_pkg::OFS_RISE_IRQ_EN, 32'h0000_0800);
        wr(eeiu_pkg::OFS_FALL_IRQ_EN, 32'h0000_0020);
        repeat (3) @(posedge clk);
        ck({27'h0, core_irq}, 32'h0000_0006);
        ck(pend_vec_addr, 32'h0000_0044);
        ck(taken_vec, 32'h0000_0044);
        ck({31'h0, stop_wake}, 32'h0000_0001);
        wr(eeiu_pkg::OFS_FALL_FLAG, 32'h0000_0000);
        wr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0000);
        repeat (3) @(posedge clk);
        ck({27'h0, core_irq}, 32'h0000_0000);
    endtask

    task automatic s_event();
        wr(eeiu_pkg::OFS_EVT_STATUS, 32'h0000_ffff);
        wr(eeiu_pkg::OFS_EVT_MASK, 32'h0000_0001);
        pin(0, 0, 1'b0);
        ck({31'h0, irq}, 32'h0000_0001);
        wr(eeiu_pkg::OFS_EVT_STATUS, 32'h0000_0001);
        repeat (3) @(posedge clk);
        ck({31'h0, irq}, 32'h0000_0000);
        wr(eeiu_pkg::OFS_EVT_MASK, 32'h0000_0000);
        pin(0, 0, 1'b1);
        ck({31'h0, irq}, 32'h0000_0000);
        cr(eeiu_pkg::OFS_EVT_STATUS, 32'h0000_0001);
        wr(eeiu_pkg::OFS_EVT_STATUS, 32'h0000_0001);
    endtask

    task automatic s_soft();
        int l;
        wr(eeiu_pkg::OFS_FALL_FLAG, 32'h0000_0000);
        wr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0000);
        wr(eeiu_pkg::OFS_RISE_IRQ_EN, 32'h0000_ffff);
        for (int i = 0; i < 4; i++) begin
            l = (i == 0) ? 0 : 4 * i + 1;
            wr(eeiu_pkg::OFS_RISE_FLAG, 32'(1 << l));
            repeat (3) @(posedge clk);
            ck({27'h0, core_irq}, 32'(1 << i));
            ck(pend_vec_addr, 32'(32'h40 + 4 * i));
            wr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0000);
        end
        wr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0001);
        wr(eeiu_pkg::OFS_CORE_EN, 32'h0000_001e);
        repeat (3) @(posedge clk);
        ck({27'h0, core_irq}, 32'h0000_0000);
        wr(eeiu_pkg::OFS_CORE_EN, 32'h0000_001f);
        wr(eeiu_pkg::OFS_RISE_FLAG, 32'h0000_0000);
        wr(eeiu_pkg::OFS_FALL_IRQ_EN, 32'h0000_8000);
        wr(eeiu_pkg::OFS_FALL_FLAG, 32'h0000_8000);
        repeat (3) @(posedge clk);
        ck({27'h0, core_irq}, 32'h0000_0008);
        wr(eeiu_pkg::OFS_FALL_IRQ_EN, 32'h0000_0000);
        repeat (3) @(posedge clk);
        ck({27'h0, core_irq}, 32'h0000_0000);
        wr(eeiu_pkg::OFS_FALL_FLAG, 32'h0000_0000);
    endtask

    // Bits: clock fail, clock enable, base timer, comparator, touch, core.
    task automatic s_wake();
        logic [5:0] w [7] = '{6'h20, 6'h30, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
        for (int i = 0; i < 7; i++) begin
            i_eeiu_far_model.set_wake(w[i]);
            repeat (3) @(posedge clk);
            ck({31'h0, stop_wake}, {31'h0, (w[i] != 6'h20 && w[i] != 0)});
            ck({27'h0, core_irq}, (w[i] == 6'h30) ? 32'h10 : 32'h0);
            if (w[i] == 6'h30) begin
                ck(pend_vec_addr, 32'h0000_0050);
            end
        end
    endtask

    initial begin
        mismatches = 0;
        samples_checked = 0;
        srst = 1'b1;
        avs = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        s_reset();
        s_rw();
        s_route();
        s_event();
        s_soft();
        s_wake();
        wr(eeiu_pkg::OFS_RISE_DET_EN, 32'h0000_ffff);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        s_reset();
        end_of_test();
    end
endmodule // tb_top
